// file: logic/fsbs_defs.svh
// constants of the frequency sweep burst sequencer: word fields, addresses, reset values
// assumes inclusion by bare name from the sequencer design file
`ifndef FSBS_DEFS_SVH
`define FSBS_DEFS_SVH
`define FSBS_WORD_W      16
`define FSBS_BIT_LAST    4'hF
`define FSBS_FIFO_DEPTH  16
`define FSBS_ADDR_CTRL   4'h0
`define FSBS_ADDR_COUNT  4'h1
`define FSBS_ADDR_DLO    4'h2
`define FSBS_ADDR_DHI    4'h3
`define FSBS_ADDR_SLO    4'hC
`define FSBS_ADDR_SHI    4'hD
`define FSBS_TOP_INT     2'h1
`define FSBS_TOP_BURST   2'h2
`define FSBS_BIT_B24     11
`define FSBS_BIT_BURST   7
`define FSBS_BIT_TRI     6
`define FSBS_BIT_EXT     5
`define FSBS_BIT_PINB    4
`define FSBS_BIT_BASE    13
`define FSBS_CTRL_RST    12'h000
`define FSBS_HALF_RST    12'h000
`define FSBS_TIME_RST    14'h0000
`define FSBS_MIDSCALE    12'h800
`endif

// file: logic/fsbs_pkg.sv
// types of the frequency sweep burst sequencer
// assumes the constants header is compiled alongside
package fsbs_pkg;
   typedef enum logic [1:0] {
      FSBS_IDLE = 2'b00,  // output held at midscale, waiting for trigger
      FSBS_RUN  = 2'b01   // sweep running
   } fsbs_state_t;
   typedef logic [23:0] fsbs_freq_t;  // frequency tuning word
endpackage

// file: logic/fsbs_sequencer.sv
// frequency sweep burst sequencer: serial word intake, word fifo, sweep engine, phase accumulator
// assumes core_clk_i at 100 MHz; serial pins, trigger and abort are asynchronous to it
`timescale 1ns/1ps
`include "fsbs_defs.svh"

// word fifo with honest full and empty
module fsbs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];  // storage
   logic [AW:0]      wr_ptr_reg;       // write pointer with wrap bit
   logic [AW:0]      rd_ptr_reg;       // read pointer with wrap bit
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_ptr_reg[AW] == rd_ptr_reg[AW])
                        || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
   assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
   assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // storage write
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
      end
   end

   // pointers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule

// sequencer top
module fsbs_sequencer (
   input  wire logic        core_clk_i,    // master clock
   input  wire logic        arst_n_i,      // async reset, active low
   input  wire logic        sclk_i,        // serial clock pin
   input  wire logic        frame_sync_n_i,// frame sync pin, active low
   input  wire logic        serial_in_i,   // serial data pin
   input  wire logic        trigger_i,     // start / step / burst pin
   input  wire logic        abort_i,       // abort pin
   output logic             rx_ready_o,    // word fifo has room
   output logic             running_o,     // sweep active
   output logic             midscale_o,    // output forced to midscale
   output logic [23:0]      freq_o,        // current tuning word
   output logic [11:0]      wave_o         // waveform sample
);
   // two-flop synchronizers plus one history flop for edges
   logic [1:0] sclk_sync_reg, fs_sync_reg, sd_sync_reg, trg_sync_reg, abt_sync_reg;
   logic       sclk_prev_reg, trg_prev_reg, abt_prev_reg;

   // input synchronizers, first stage read only by second
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_sync_reg <= 2'b11;
         fs_sync_reg   <= 2'b11;
         sd_sync_reg   <= 2'b00;
         trg_sync_reg  <= 2'b00;
         abt_sync_reg  <= 2'b00;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
         fs_sync_reg   <= {fs_sync_reg[0], frame_sync_n_i};
         sd_sync_reg   <= {sd_sync_reg[0], serial_in_i};
         trg_sync_reg  <= {trg_sync_reg[0], trigger_i};
         abt_sync_reg  <= {abt_sync_reg[0], abort_i};
      end
   end

   // edge history
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_prev_reg <= 1'b1;
         trg_prev_reg  <= 1'b0;
         abt_prev_reg  <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_sync_reg[1];
         trg_prev_reg  <= trg_sync_reg[1];
         abt_prev_reg  <= abt_sync_reg[1];
      end
   end

   logic sclk_fall, trg_rise, abt_rise, fs_low, trg_level;
   assign fs_low    = !fs_sync_reg[1];
   assign sclk_fall = sclk_prev_reg && !sclk_sync_reg[1] && fs_low;
   assign trg_rise  = trg_sync_reg[1] && !trg_prev_reg;
   assign abt_rise  = abt_sync_reg[1] && !abt_prev_reg;
   assign trg_level = trg_sync_reg[1];

   // serial shifter
   logic [15:0] shift_reg;     // incoming bits, address first
   logic [3:0]  bit_cnt_reg;   // bits taken of current word
   logic        word_vld_reg;  // complete word waiting for fifo
   logic [15:0] word_reg;      // complete word

   // shift one bit per falling serial clock edge while framed
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_reg   <= 16'h0000;
         bit_cnt_reg <= 4'h0;
      end else if (!fs_low) begin
         bit_cnt_reg <= 4'h0;
      end else if (sclk_fall) begin
         shift_reg   <= {shift_reg[14:0], sd_sync_reg[1]};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   logic push_ready;
   // word hand-off to the fifo; a full fifo drops the word
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word_vld_reg <= 1'b0;
         word_reg     <= 16'h0000;
      end else begin
         word_vld_reg <= fs_low && sclk_fall && (bit_cnt_reg == `FSBS_BIT_LAST);
         if (fs_low && sclk_fall && (bit_cnt_reg == `FSBS_BIT_LAST)) begin
            word_reg <= {shift_reg[14:0], sd_sync_reg[1]};
         end
      end
   end

   logic        rd_valid, rd_ready;
   logic [15:0] rd_word;
   fsbs_fifo #(.WIDTH(`FSBS_WORD_W), .DEPTH(`FSBS_FIFO_DEPTH)) u_fifo (
      .core_clk_i  (core_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (word_vld_reg),
      .in_ready_o  (push_ready),
      .in_data_i   (word_reg),
      .out_valid_o (rd_valid),
      .out_ready_i (rd_ready),
      .out_data_o  (rd_word)
   );
   assign rx_ready_o = push_ready;

   // register side: one word every other cycle
   logic        apply_busy_reg;
   logic        take;
   logic        ctrl_wr;
   logic [11:0] ctrl_reg, count_reg, dlo_reg, dhi_reg, slo_reg, shi_reg, pend_reg;
   logic [13:0] int_reg, burst_reg;
   assign rd_ready = !apply_busy_reg;
   assign take     = rd_valid && rd_ready;
   assign ctrl_wr  = take && (rd_word[15:12] == `FSBS_ADDR_CTRL);

   // drain pacing
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) apply_busy_reg <= 1'b0;
      else           apply_busy_reg <= take;
   end

   // parameter registers; paired halves commit together when b24 set
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_reg  <= `FSBS_CTRL_RST;
         count_reg <= `FSBS_HALF_RST;
         dlo_reg   <= `FSBS_HALF_RST;
         dhi_reg   <= `FSBS_HALF_RST;
         slo_reg   <= `FSBS_HALF_RST;
         shi_reg   <= `FSBS_HALF_RST;
         pend_reg  <= `FSBS_HALF_RST;
         int_reg   <= `FSBS_TIME_RST;
         burst_reg <= `FSBS_TIME_RST;
      end else if (take) begin
         if (rd_word[15:14] == `FSBS_TOP_INT) int_reg <= rd_word[13:0];
         else if (rd_word[15:14] == `FSBS_TOP_BURST) burst_reg <= rd_word[13:0];
         else begin
            unique case (rd_word[15:12])
               `FSBS_ADDR_CTRL:  ctrl_reg  <= rd_word[11:0];
               `FSBS_ADDR_COUNT: count_reg <= rd_word[11:0];
               `FSBS_ADDR_DLO: begin
                  if (ctrl_reg[`FSBS_BIT_B24]) pend_reg <= rd_word[11:0];
                  else dlo_reg <= rd_word[11:0];
               end
               `FSBS_ADDR_DHI: begin
                  dhi_reg <= rd_word[11:0];
                  if (ctrl_reg[`FSBS_BIT_B24]) dlo_reg <= pend_reg;
               end
               `FSBS_ADDR_SLO: begin
                  if (ctrl_reg[`FSBS_BIT_B24]) pend_reg <= rd_word[11:0];
                  else slo_reg <= rd_word[11:0];
               end
               `FSBS_ADDR_SHI: begin
                  shi_reg <= rd_word[11:0];
                  if (ctrl_reg[`FSBS_BIT_B24]) slo_reg <= pend_reg;
               end
               default: ;  // reserved addresses ignored
            endcase
         end
      end
   end

   logic burst_mode, tri_mode, ext_mode, pin_burst;
   assign burst_mode = ctrl_reg[`FSBS_BIT_BURST];
   assign tri_mode   = ctrl_reg[`FSBS_BIT_TRI];
   assign ext_mode   = ctrl_reg[`FSBS_BIT_EXT];
   assign pin_burst  = ctrl_reg[`FSBS_BIT_PINB];

   // sweep engine
   fsbs_pkg::fsbs_state_t state_reg;
   fsbs_pkg::fsbs_freq_t  freq_reg, start_w, delta_w;
   logic [11:0] idx_reg;       // increments taken
   logic        down_reg;      // descending leg of up/down sweep
   logic [13:0] tint_cnt_reg;  // interval progress
   logic [13:0] burst_cnt_reg; // burst progress
   logic [23:0] phase_reg;     // phase accumulator
   logic        msb_prev_reg;  // for output cycle ticks
   logic        kill, start, step, cyc_tick, int_tick, bst_tick, int_done, at_top;
   assign start_w  = {shi_reg, slo_reg};
   assign delta_w  = {dhi_reg, dlo_reg};
   assign kill     = abt_rise || ctrl_wr;
   assign start    = trg_rise && (state_reg == fsbs_pkg::FSBS_IDLE) && !kill;
   assign cyc_tick = phase_reg[23] && !msb_prev_reg;
   assign int_tick = int_reg[`FSBS_BIT_BASE] ? cyc_tick : 1'b1;
   assign bst_tick = burst_reg[`FSBS_BIT_BASE] ? cyc_tick : 1'b1;
   assign int_done = int_tick && ({1'b0, tint_cnt_reg[12:0]} + 14'h0001
                                  >= {1'b0, int_reg[12:0]});
   assign at_top   = (idx_reg == count_reg);
   assign step     = (state_reg == fsbs_pkg::FSBS_RUN) && !kill
                     && (ext_mode ? trg_rise : int_done);

   // state
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) state_reg <= fsbs_pkg::FSBS_IDLE;
      else if (kill) state_reg <= fsbs_pkg::FSBS_IDLE;
      else if (start) state_reg <= fsbs_pkg::FSBS_RUN;
   end

   // frequency walk
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         freq_reg <= 24'h00_0000;
         idx_reg  <= 12'h000;
         down_reg <= 1'b0;
      end else if (start) begin
         freq_reg <= start_w;
         idx_reg  <= 12'h000;
         down_reg <= 1'b0;
      end else if (step) begin
         if (!tri_mode) begin
            if (at_top) begin
               freq_reg <= start_w;
               idx_reg  <= 12'h000;
            end else begin
               freq_reg <= freq_reg + delta_w;
               idx_reg  <= idx_reg + 12'h001;
            end
         end else if (!down_reg) begin
            if (at_top) begin
               down_reg <= (count_reg != 12'h000);
               freq_reg <= (count_reg != 12'h000) ? freq_reg - delta_w : freq_reg;
               idx_reg  <= (count_reg != 12'h000) ? idx_reg - 12'h001 : idx_reg;
            end else begin
               freq_reg <= freq_reg + delta_w;
               idx_reg  <= idx_reg + 12'h001;
            end
         end else begin
            freq_reg <= freq_reg - delta_w;
            idx_reg  <= idx_reg - 12'h001;
            if (idx_reg == 12'h001) down_reg <= 1'b0;
         end
      end
   end

   // interval and burst timers restart at every step
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tint_cnt_reg  <= 14'h0000;
         burst_cnt_reg <= 14'h0000;
      end else if (start || step || state_reg == fsbs_pkg::FSBS_IDLE) begin
         tint_cnt_reg  <= 14'h0000;
         burst_cnt_reg <= 14'h0000;
      end else begin
         if (int_tick) tint_cnt_reg <= tint_cnt_reg + 14'h0001;
         if (bst_tick && burst_cnt_reg[12:0] < burst_reg[12:0]) begin
            burst_cnt_reg <= burst_cnt_reg + 14'h0001;
         end
      end
   end

   logic quiet;
   assign quiet = (state_reg == fsbs_pkg::FSBS_IDLE)
                  || (pin_burst && !trg_level)
                  || (burst_mode && !pin_burst
                      && burst_cnt_reg[12:0] >= burst_reg[12:0]);

   // phase accumulator; zeroed at burst step starts and when quiet in burst
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase_reg    <= 24'h00_0000;
         msb_prev_reg <= 1'b0;
      end else begin
         msb_prev_reg <= phase_reg[23];
         if (kill || start || (step && burst_mode) || (quiet && burst_mode)) begin
            phase_reg <= 24'h00_0000;
         end else if (state_reg == fsbs_pkg::FSBS_RUN) begin
            phase_reg <= phase_reg + freq_reg;
         end
      end
   end

   // registered outputs
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         midscale_o <= 1'b1;
         wave_o     <= `FSBS_MIDSCALE;
         freq_o     <= 24'h00_0000;
         running_o  <= 1'b0;
      end else begin
         midscale_o <= quiet || kill;
         wave_o     <= (quiet || kill) ? `FSBS_MIDSCALE : phase_reg[23:12];
         freq_o     <= freq_reg;
         running_o  <= (state_reg == fsbs_pkg::FSBS_RUN) && !kill;
      end
   end

   // checks
   sequence s_abort;
      abt_rise;
   endsequence
   sequence s_idle_quiet;
      (state_reg == fsbs_pkg::FSBS_IDLE) ##1 midscale_o;
   endsequence
   property p_abort;
      @(posedge core_clk_i) disable iff (!arst_n_i) s_abort |=> s_idle_quiet;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not idle");
   property p_ctrl_wr;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         ctrl_wr |=> (state_reg == fsbs_pkg::FSBS_IDLE) && midscale_o;
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write no reset");
   property p_start;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         start |=> (state_reg == fsbs_pkg::FSBS_RUN) && (freq_reg == $past(start_w));
   endproperty
   a_start: assert property (p_start) else $error("trigger did not start");
   property p_word;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (sclk_fall && bit_cnt_reg == `FSBS_BIT_LAST) |=> word_vld_reg ##1 !word_vld_reg;
   endproperty
   a_word: assert property (p_word) else $error("word not formed");
   property p_frame;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         !fs_low |=> (bit_cnt_reg == 4'h0) && !word_vld_reg;
   endproperty
   a_frame: assert property (p_frame) else $error("bits taken unframed");
   property p_saw;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (step && !tri_mode && at_top) |=> (freq_reg == start_w) && (idx_reg == 12'h000);
   endproperty
   a_saw: assert property (p_saw) else $error("saw did not wrap");
   property p_tri;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (step && tri_mode && !down_reg && at_top && count_reg != 12'h000) |=> down_reg;
   endproperty
   a_tri: assert property (p_tri) else $error("up down did not turn");
   property p_burst_phase;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (step && burst_mode) |=> (phase_reg == 24'h00_0000);
   endproperty
   a_burst_phase: assert property (p_burst_phase) else $error("burst step phase");
   property p_cont;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (state_reg == fsbs_pkg::FSBS_RUN && !burst_mode && !pin_burst && !kill)
            |=> !midscale_o;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous output gapped");
endmodule

// file: verif/fsbs_host_model.sv
// host model: drives the serial port, trigger and abort pins of the sequencer
// assumes the bench calls its tasks hierarchically; sclk idles high outside frames
`timescale 1ns/1ps

module fsbs_host_model (
   input  wire logic core_clk_i,     // master clock, used only to pace the trigger and abort pins
   output logic      sclk_o,         // serial clock, stands high between frames
   output logic      frame_sync_n_o, // frame sync, active low
   output logic      serial_in_o,    // serial data
   output logic      trigger_o,      // start / step / burst pin
   output logic      abort_o         // abort pin
);
   // idle pins at time zero
   initial begin
      sclk_o         = 1'b1;
      frame_sync_n_o = 1'b1;
      serial_in_o    = 1'b0;
      trigger_o      = 1'b0;
      abort_o        = 1'b0;
   end

   // frame sync low before the first falling edge
   task automatic open_frame;
      frame_sync_n_o = 1'b0;
      #62.5;
   endtask

   // shift nbits of w, address nibble first, msb first, 125 ns per bit
   task automatic shift(input logic [15:0] w, input int nbits);
      for (int i = 15; i > 15 - nbits; i--) begin
         serial_in_o = w[i];
         #62.5 sclk_o = 1'b0;
         #62.5 sclk_o = 1'b1;
      end
   endtask

   // release only after the last falling edge; data no longer holds its value
   task automatic close_frame;
      #62.5;
      frame_sync_n_o = 1'b1;
      serial_in_o    = ~serial_in_o;
   endtask

   // one complete word in its own frame; sclk stands still afterwards
   task automatic word(input logic [15:0] w);
      open_frame();
      shift(w, 16);
      close_frame();
   endtask

   // one rising edge on the trigger pin, held for several master clocks
   task automatic pulse_trigger;
      @(negedge core_clk_i);
      trigger_o = 1'b1;
      repeat (6) @(negedge core_clk_i);
      trigger_o = 1'b0;
   endtask

   // trigger level for pin-controlled bursting
   task automatic set_trigger(input logic lvl);
      @(negedge core_clk_i);
      trigger_o = lvl;
   endtask

   // one rising edge on the abort pin
   task automatic pulse_abort;
      @(negedge core_clk_i);
      abort_o = 1'b1;
      repeat (6) @(negedge core_clk_i);
      abort_o = 1'b0;
   endtask
endmodule

// file: verif/fsbs_sequencer_bench.sv
// self-checking bench of the sweep sequencer, host model on the serial side
// assumes 100 MHz master clock; expectations come from the programmed words
`timescale 1ns/1ps

module fsbs_sequencer_bench;
   localparam logic [23:0] START = 24'h12_3456; // start tuning word
   localparam logic [23:0] DELTA = 24'h00_0100; // step increment
   localparam int          LIMIT = 20000;       // cycle ceiling of the run

   logic        core_clk;        // master clock
   logic        arst_n;          // reset, active low
   logic        sclk;            // serial clock from host
   logic        frame_sync_n;    // frame sync from host
   logic        serial_in;       // serial data from host
   logic        trigger;         // trigger pin
   logic        abort_pin;       // abort pin
   logic        rx_ready;        // fifo room
   logic        running;         // sweep active
   logic        midscale;        // output parked
   logic [23:0] freq;            // tuning word out
   logic [11:0] wave;            // sample out
   int          miscompares;     // mismatches seen
   int          samples_checked; // comparisons made
   int          cycles;          // timeout counter
   int          n;               // cycles between steps
   // start, two increments, count 2, 10 clock interval, 3 clock burst
   logic [15:0] params [7] = '{16'hC456, 16'hD123, 16'h2100, 16'h3000,
                               16'h1002, 16'h400A, 16'h8003};
   logic [23:0] updown [4] = '{START + DELTA, START + DELTA + DELTA, START + DELTA, START};

   fsbs_sequencer dut (
      .core_clk_i     (core_clk),
      .arst_n_i       (arst_n),
      .sclk_i         (sclk),
      .frame_sync_n_i (frame_sync_n),
      .serial_in_i    (serial_in),
      .trigger_i      (trigger),
      .abort_i        (abort_pin),
      .rx_ready_o     (rx_ready),
      .running_o      (running),
      .midscale_o     (midscale),
      .freq_o         (freq),
      .wave_o         (wave)
   );

   fsbs_host_model host (
      .core_clk_i     (core_clk),
      .sclk_o         (sclk),
      .frame_sync_n_o (frame_sync_n),
      .serial_in_o    (serial_in),
      .trigger_o      (trigger),
      .abort_o        (abort_pin)
   );

   // 100 MHz master clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // verdict and end of run
   task automatic tally_and_finish;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // one comparison, mismatch reported at once
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // wait bounded for running (sel 0) or midscale (sel 1) to reach lvl
   task automatic wait_for(input int sel, input logic lvl);
      int k;
      k = 0;
      while ((sel == 0 ? running : midscale) !== lvl && k < 100) begin
         @(negedge core_clk);
         k++;
      end
      check(sel == 0 ? running : midscale, lvl, sel == 0 ? "running" : "midscale");
   endtask

   // wait bounded for the tuning word to move, counting cycles
   task automatic next_freq(output int cnt);
      logic [23:0] old;
      old = freq;
      cnt = 0;
      while (freq === old && cnt < 200) begin
         @(negedge core_clk);
         cnt++;
      end
      check(freq !== old, 1'b1, "tuning word moved");
   endtask

   // control word in its own frame, then let the fifo drain
   task automatic ctrl(input logic [15:0] w);
      host.word(w);
      repeat (10) @(negedge core_clk);
   endtask

   // main sequence
   initial begin
      arst_n = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(negedge core_clk);
      check(running, 1'b0, "reset running");
      check(midscale, 1'b1, "reset midscale");
      check(wave, 12'h800, "reset wave");
      check(freq, 24'h00_0000, "reset freq");
      check(rx_ready, 1'b1, "reset rx_ready");
      arst_n = 1'b1;
      // saw, continuous, auto step; parameters back to back in one frame
      ctrl(16'h0000);
      host.open_frame();
      foreach (params[i]) host.shift(params[i], 16);
      host.close_frame();
      repeat (20) @(negedge core_clk);
      check(running, 1'b0, "idle before trigger");
      host.pulse_trigger();
      wait_for(0, 1'b1);
      check(freq, START, "sweep start");
      next_freq(n);
      check(freq, START + DELTA, "first step");
      next_freq(n);
      check(freq, START + DELTA + DELTA, "second step");
      check(n, 10, "clock interval");
      next_freq(n);
      check(freq, START, "saw jump back");
      check(n, 10, "end interval");
      check(midscale, 1'b0, "continuous output");
      // partial word under frame sync is dropped, sweep goes on
      host.open_frame();
      host.shift(16'h0040, 8);
      host.close_frame();
      repeat (20) @(negedge core_clk);
      check(running, 1'b1, "partial word ignored");
      // up/down; control write parks the output
      host.word(16'h0040);
      wait_for(1, 1'b1);
      check(running, 1'b0, "ctrl write stops");
      host.pulse_trigger();
      wait_for(0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         next_freq(n);
         check(freq, updown[k], "up/down step");
      end
      // abort
      host.pulse_abort();
      wait_for(1, 1'b1);
      check(running, 1'b0, "abort stops");
      check(wave, 12'h800, "abort midscale");
      // burst output mode
      ctrl(16'h0080);
      host.pulse_trigger();
      wait_for(0, 1'b1);
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      check(wave, 12'h800, "listen midscale");
      // external stepping
      ctrl(16'h0020);
      host.pulse_trigger();
      wait_for(0, 1'b1);
      repeat (40) @(negedge core_clk);
      check(freq, START, "ext holds");
      host.pulse_trigger();
      check(freq, START + DELTA, "ext step");
      // trigger pin gates the output
      ctrl(16'h0030);
      host.set_trigger(1'b1);
      wait_for(1, 1'b0);
      host.set_trigger(1'b0);
      wait_for(1, 1'b1);
      check(wave, 12'h800, "pin burst low");
      // interval in output cycles: two msb periods of about 14 clocks each
      ctrl(16'h0000);
      host.word(16'h6002);
      repeat (10) @(negedge core_clk);
      host.pulse_trigger();
      wait_for(0, 1'b1);
      next_freq(n);
      next_freq(n);
      check(n >= 27 && n <= 30, 1'b1, "output cycle interval");
      tally_and_finish();
   end
endmodule
